// >>> pkg/serial_mp_pkg.sv
// Purpose: Shared constants and types of the multiprocessor serial unit.
// Assumes: AXI4-Lite register access, one 40 MHz clock.
// Notes: Register offsets are byte addresses of aligned 32-bit words.
`default_nettype none
package serial_mp_pkg;
  // Register map
  localparam int unsigned ADDR_W = 6;
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_BAUD = 6'h04;
  localparam logic [5:0] OFS_TXBUF = 6'h08;
  localparam logic [5:0] OFS_RXBUF = 6'h0c;
  localparam logic [5:0] OFS_STAT = 6'h10;
  localparam logic [5:0] OFS_IRQ_STAT = 6'h14;
  localparam logic [5:0] OFS_IRQ_CLR = 6'h18;
  localparam logic [5:0] OFS_IRQ_EN = 6'h1c;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Serial modes
  localparam logic [2:0] MODE_7BIT = 3'h4;
  localparam logic [2:0] MODE_8BIT = 3'h5;
  // Field positions
  localparam int unsigned TXB_MP = 8;
  localparam int unsigned RXB_MP = 8;
  localparam int unsigned RXB_OER = 12;
  localparam int unsigned RXB_FER = 13;
  localparam int unsigned RXB_PER = 14;
  localparam int unsigned ST_TXE = 0;
  localparam int unsigned ST_RXC = 1;
  localparam int unsigned ST_SKIP = 2;
  localparam int unsigned ST_SCLW = 3;
  localparam int unsigned ST_BUSY = 4;
  localparam int unsigned IRQ_W = 5;
  localparam int unsigned EV_TXE = 0;
  localparam int unsigned EV_RXC = 1;
  localparam int unsigned EV_ERR = 2;
  localparam int unsigned EV_ID = 3;
  localparam int unsigned EV_START = 4;
  // Counts
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] SYNC_DATA_BITS = 4'h8;
  localparam logic [3:0] SCL_WAIT_PULSE = 4'h9;
  localparam int unsigned FILTER_STAGES = 3;
  localparam logic [15:0] BAUD_RST = 16'h0001;
  localparam int unsigned CTRL_W = 13;

  typedef struct packed {
    logic ext_clk_sel;
    logic start_detect_init_enable;
    logic rx_filter_enable;
    logic rx_enable;
    logic tx_enable;
    logic multiproc_skip_enable;
    logic mp_format;
    logic parity_odd;
    logic parity_en;
    logic two_stop;
    logic [2:0] serial_mode_field;
  } ctrl_t;
  localparam ctrl_t CTRL_RST = ctrl_t'(13'h0000);

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

  typedef struct packed {
    logic txd;
    logic scl_out;
    logic scl_oe_n;
  } pins_t;
endpackage
`default_nettype wire

// >>> rtl/rx_noise_filter.sv
// Purpose: Three-latch noise canceller on the receive input.
// Assumes: sample pulses at 16 times the bit rate.
// Notes: Bypassed (one register stage) while disabled.
`default_nettype none
module rx_noise_filter #(
  parameter int unsigned STAGES = serial_mp_pkg::FILTER_STAGES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sample,
  input wire logic enable,
  input wire logic din,
  output logic dout
);
  import serial_mp_pkg::*;

  typedef struct packed {
    logic [STAGES-1:0] sh;
    logic out;
  } fst_t;

  fst_t st_r;
  fst_t st_nxt;

  if (STAGES < 2) begin : g_chk
    $error("rx_noise_filter needs at least two stages");
  end

  // Latch chain advances only on the oversampling pulse
  always_comb
  begin
    st_nxt = st_r;
    if (sample)
    begin
      st_nxt.sh = {st_r.sh[STAGES-2:0], din}; // R17
      if (&st_r.sh)
        st_nxt.out = 1'b1; // R18
      else if (~|st_r.sh)
        st_nxt.out = 1'b0; // R18
    end
    if (!enable)
      st_nxt.out = din; // R16
  end

  // Idle line is high, so reset to high
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r.sh <= '1;
      st_r.out <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  assign dout = st_r.out;
endmodule
`default_nettype wire

// >>> rtl/serial_mp_uart.sv
// Purpose: Asynchronous serial unit with multiprocessor format and start-triggered init.
// Assumes: Pins synchronous to aclk; AXI4-Lite slave with 32-bit data.
// Notes: Start-triggered transfers are clocked by the external serial clock line.
// Overview of operation
// (R01) Start detect reloads transmit shifter from buffer
// (R02) Data output holds level until first bit
// (R03) Start detect clears receive shifter, restarts capture
// (R04) Start detect arms clock low after ninth
// (R05) Start-triggered transfer keeps buffer-empty flag
// (R06) Software selects external clock for this; the code stores ext_clk_sel but never reads it, and always clocks on scl_in
// (R07) Extra bit: one is ID, zero data
// (R08) Sender sets extra bit per frame type
// (R09) Receiver software compares ID, decides skipping
// (R10) Skipping blocks buffer load, errors, flags
// (R11) ID frame sets received bit, ends skipping
// (R12) ID frame during skip stored, raises completion
// (R13) Multiprocessor format ignores parity setting
// (R14) Software picks mode 100b or 101b
// (R15) Received extra bit tells ID or data
// (R16) Filter enable routes input through canceller
// (R17) Filter samples at sixteen times bit rate
// (R18) Filter passes level only when latches agree
// (R19) Extra bit sits after data, before stop
`default_nettype none
module serial_mp_uart #(
  parameter int unsigned BAUD_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [serial_mp_pkg::ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [serial_mp_pkg::ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic rx_data_input,
  input wire logic scl_in,
  output serial_mp_pkg::pins_t pins,
  output logic irq
);
  import serial_mp_pkg::*;

  if (BAUD_W < 2 || BAUD_W > 32) begin : g_chk
    $error("serial_mp_uart: BAUD_W must lie in 2..32");
  end

  typedef struct packed {
    ctrl_t ctrl;
    logic [BAUD_W-1:0] baud;
    logic [BAUD_W-1:0] baud_cnt;
    logic tick;
    logic [8:0] tx_buf;
    logic txe;
    logic tx_busy;
    logic [11:0] tx_sh;
    logic [3:0] tx_left;
    logic [3:0] tx_os;
    rx_state_t rx_st;
    logic [3:0] rx_os;
    logic [3:0] rx_cnt;
    logic [8:0] rx_sh;
    logic [14:0] rx_buf;
    logic rxc;
    logic sync_act;
    logic [3:0] sync_rise;
    logic [7:0] sync_tx;
    logic [7:0] sync_rx;
    logic scl_prev;
    logic rxd_prev;
    logic scl_wait;
    logic scl_hold;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    pins_t pins;
    logic irq;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } st_t;

  st_t st_r;
  st_t st_nxt;
  logic filt;
  logic [IRQ_W-1:0] ev;
  logic [31:0] merged;
  logic start_det;
  logic scl_rise;
  logic scl_fall;
  logic mode_ok;
  logic [3:0] nbits;
  logic [8:0] al;
  logic [7:0] rx_d;
  logic rx_extra;
  logic rx_mpb;
  logic rx_fer;
  logic rx_per;

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] stb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (stb[i])
        r[8*i +: 8] = wd[8*i +: 8];
    return r;
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return a == OFS_CTRL || a == OFS_BAUD || a == OFS_TXBUF || a == OFS_RXBUF ||
           a == OFS_STAT || a == OFS_IRQ_STAT || a == OFS_IRQ_CLR || a == OFS_IRQ_EN;
  endfunction

  function automatic logic [3:0] data_bits(input ctrl_t c);
    return (c.serial_mode_field == MODE_8BIT) ? 4'h8 : 4'h7;
  endfunction

  // Parity ignored when the multiprocessor bit takes its slot
  function automatic logic has_extra(input ctrl_t c);
    return c.mp_format | c.parity_en; // R13
  endfunction

  function automatic logic par_of(input ctrl_t c, input logic [7:0] d);
    return (^d) ^ c.parity_odd;
  endfunction

  // Start, data LSB first, extra bit, then stop ones
  function automatic logic [11:0] tx_frame(input ctrl_t c, input logic [8:0] tb);
    logic [11:0] f;
    logic [7:0] d;
    logic [3:0] db;
    db = data_bits(c);
    d = (db == 4'h8) ? tb[7:0] : {1'b0, tb[6:0]};
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < 8; i++)
      if (i < int'(db))
        f[i+1] = d[i];
    if (has_extra(c))
      f[db+4'h1] = c.mp_format ? tb[TXB_MP] : par_of(c, d); // R19 R07
    return f;
  endfunction

  function automatic logic [3:0] tx_len(input ctrl_t c);
    return 4'h1 + data_bits(c) + {3'h0, has_extra(c)} + (c.two_stop ? 4'h2 : 4'h1);
  endfunction

  function automatic logic [31:0] rd_word(input st_t s, input logic [ADDR_W-1:0] a);
    logic [31:0] r;
    r = '0;
    unique case (a)
      OFS_CTRL: r = 32'(s.ctrl);
      OFS_BAUD: r = 32'(s.baud);
      OFS_TXBUF: r = 32'(s.tx_buf);
      OFS_RXBUF: r = 32'(s.rx_buf);
      OFS_STAT: r = 32'({s.tx_busy | s.sync_act, s.scl_wait, s.ctrl.multiproc_skip_enable, s.rxc, s.txe});
      OFS_IRQ_STAT: r = 32'(s.irq_stat);
      OFS_IRQ_EN: r = 32'(s.irq_en);
      default: r = '0;
    endcase
    return r;
  endfunction

  rx_noise_filter #(
    .STAGES(FILTER_STAGES)
  ) u_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .sample(st_r.tick),
    .enable(st_r.ctrl.rx_filter_enable),
    .din(rx_data_input),
    .dout(filt)
  );

  // Whole next-state; bus first so that hardware sets win over clears
  always_comb
  begin
    st_nxt = st_r;
    ev = '0;
    // Old word of the addressed register, so one merge serves the control, baud and transmit buffer registers
    merged = merge(rd_word(st_r, st_r.awaddr), st_r.wdata, st_r.wstrb);
    mode_ok = st_r.ctrl.serial_mode_field == MODE_7BIT || st_r.ctrl.serial_mode_field == MODE_8BIT;
    nbits = data_bits(st_r.ctrl) + {3'h0, has_extra(st_r.ctrl)};
    al = st_r.rx_sh >> (4'h9 - nbits);
    rx_d = (data_bits(st_r.ctrl) == 4'h8) ? al[7:0] : {1'b0, al[6:0]};
    rx_extra = al[data_bits(st_r.ctrl)];
    rx_mpb = st_r.ctrl.mp_format & rx_extra;
    rx_fer = !filt;
    rx_per = st_r.ctrl.parity_en & !st_r.ctrl.mp_format & (rx_extra != par_of(st_r.ctrl, rx_d)); // R13
    scl_rise = scl_in & !st_r.scl_prev;
    scl_fall = !scl_in & st_r.scl_prev;
    start_det = st_r.ctrl.start_detect_init_enable & scl_in & st_r.scl_prev & st_r.rxd_prev & !rx_data_input;
    st_nxt.scl_prev = scl_in;
    st_nxt.rxd_prev = rx_data_input;

    // Oversampling tick at 16x bit rate
    st_nxt.tick = 1'b0;
    if (st_r.baud_cnt == '0)
    begin
      st_nxt.baud_cnt = st_r.baud;
      st_nxt.tick = 1'b1; // R17
    end
    else
      st_nxt.baud_cnt = st_r.baud_cnt - 1'b1;

    // AXI write: address and data taken in either order
    if (st_r.awready && awvalid)
    begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = awaddr;
    end
    if (st_r.wready && wvalid)
    begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = wdata;
      st_nxt.wstrb = wstrb;
    end
    if (st_r.bvalid && bready)
      st_nxt.bvalid = 1'b0;
    if (st_r.aw_got && st_r.w_got && !st_r.bvalid)
    begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = mapped(st_r.awaddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (st_r.awaddr)
        OFS_CTRL: st_nxt.ctrl = ctrl_t'(merged[CTRL_W-1:0]);
        OFS_BAUD: st_nxt.baud = merged[BAUD_W-1:0];
        OFS_TXBUF:
        begin
          st_nxt.tx_buf = merged[8:0];
          st_nxt.txe = 1'b0;
        end
        OFS_STAT:
          if (st_r.wstrb[0] && !st_r.wdata[ST_SCLW])
            st_nxt.scl_wait = 1'b0;
        OFS_IRQ_CLR:
          if (st_r.wstrb[0])
            st_nxt.irq_stat = st_r.irq_stat & ~st_r.wdata[IRQ_W-1:0];
        OFS_IRQ_EN:
          if (st_r.wstrb[0])
            st_nxt.irq_en = st_r.wdata[IRQ_W-1:0];
        default: st_nxt.bresp = RESP_SLVERR;
      endcase
    end
    st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_got && !st_nxt.bvalid;

    // AXI read; reading the receive buffer clears completion
    if (st_r.rvalid && rready)
      st_nxt.rvalid = 1'b0;
    if (st_r.arready && arvalid)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rd_word(st_r, araddr);
      st_nxt.rresp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      if (araddr == OFS_RXBUF)
        st_nxt.rxc = 1'b0;
    end
    st_nxt.arready = !st_nxt.rvalid;

    // Asynchronous transmitter, one bit per 16 ticks
    if (!st_r.tx_busy)
    begin
      if (st_r.ctrl.tx_enable && mode_ok && !st_r.txe && !st_r.sync_act)
      begin
        st_nxt.tx_sh = tx_frame(st_r.ctrl, st_r.tx_buf);
        st_nxt.tx_left = tx_len(st_r.ctrl);
        st_nxt.tx_os = '0;
        st_nxt.tx_busy = 1'b1;
        st_nxt.txe = 1'b1;
        ev[EV_TXE] = 1'b1;
      end
    end
    else if (st_r.tick)
    begin
      st_nxt.tx_os = st_r.tx_os + 1'b1;
      if (st_r.tx_os == '0)
      begin
        st_nxt.pins.txd = st_r.tx_sh[0];
        st_nxt.tx_sh = {1'b1, st_r.tx_sh[11:1]};
      end
      if (st_r.tx_os == OVS_LAST)
      begin
        st_nxt.tx_left = st_r.tx_left - 1'b1;
        if (st_r.tx_left == 4'h1)
          st_nxt.tx_busy = 1'b0;
      end
    end

    // Asynchronous receiver on the filtered input
    if (!st_r.ctrl.rx_enable || !mode_ok || st_r.sync_act)
      st_nxt.rx_st = RX_IDLE;
    else if (st_r.tick)
    begin
      st_nxt.rx_os = st_r.rx_os + 1'b1;
      unique case (st_r.rx_st)
        RX_IDLE:
          if (!filt)
          begin
            st_nxt.rx_st = RX_START;
            st_nxt.rx_os = '0;
          end
        RX_START:
          if (st_r.rx_os == OVS_MID)
          begin
            st_nxt.rx_st = filt ? RX_IDLE : RX_DATA;
            st_nxt.rx_os = '0;
            st_nxt.rx_cnt = '0;
          end
        RX_DATA:
          if (st_r.rx_os == OVS_LAST)
          begin
            st_nxt.rx_sh = {filt, st_r.rx_sh[8:1]};
            st_nxt.rx_cnt = st_r.rx_cnt + 1'b1;
            if (st_r.rx_cnt + 1'b1 == nbits)
              st_nxt.rx_st = RX_STOP;
          end
        RX_STOP:
          if (st_r.rx_os == OVS_LAST)
          begin
            st_nxt.rx_st = RX_IDLE;
            // Skipped data frames leave buffer and flags alone
            if (!st_r.ctrl.multiproc_skip_enable || rx_mpb) // R10
            begin
              st_nxt.rx_buf = '0;
              st_nxt.rx_buf[7:0] = rx_d; // R12
              st_nxt.rx_buf[RXB_MP] = rx_mpb; // R11 R15
              if (!st_r.ctrl.multiproc_skip_enable)
              begin
                st_nxt.rx_buf[RXB_OER] = st_r.rxc;
                st_nxt.rx_buf[RXB_FER] = rx_fer;
                st_nxt.rx_buf[RXB_PER] = rx_per;
                ev[EV_ERR] = st_r.rxc | rx_fer | rx_per;
              end
              st_nxt.rxc = 1'b1; // R12
              ev[EV_RXC] = 1'b1;
              if (rx_mpb)
              begin
                st_nxt.ctrl.multiproc_skip_enable = 1'b0; // R11
                ev[EV_ID] = 1'b1; // R07
              end
            end
          end
      endcase
    end

    // Start-triggered transfer, clocked by the serial clock line
    if (start_det)
    begin
      st_nxt.sync_act = 1'b1;
      st_nxt.sync_tx = st_r.tx_buf[7:0]; // R01
      st_nxt.tx_busy = 1'b0; // R01
      st_nxt.sync_rx = '0; // R03
      st_nxt.sync_rise = '0; // R03
      st_nxt.rx_st = RX_IDLE; // R03
      st_nxt.scl_wait = 1'b1; // R04
      st_nxt.pins.txd = st_r.pins.txd; // R02
      st_nxt.txe = st_r.txe; // R05
      ev[EV_START] = 1'b1;
    end
    else if (st_r.sync_act)
    begin
      if (scl_rise && st_r.sync_rise < SCL_WAIT_PULSE)
      begin
        st_nxt.sync_rise = st_r.sync_rise + 1'b1;
        if (st_r.sync_rise < SYNC_DATA_BITS)
          st_nxt.sync_rx = {st_r.sync_rx[6:0], rx_data_input}; // R03
      end
      if (scl_fall)
      begin
        if (st_r.sync_rise < SYNC_DATA_BITS)
        begin
          st_nxt.pins.txd = st_r.sync_tx[7]; // R02
          st_nxt.sync_tx = {st_r.sync_tx[6:0], 1'b1};
        end
        else if (st_r.sync_rise == SYNC_DATA_BITS)
          st_nxt.pins.txd = 1'b1;
        else
        begin
          st_nxt.sync_act = 1'b0;
          st_nxt.rx_buf = 15'(st_r.sync_rx);
          st_nxt.rxc = 1'b1;
          ev[EV_RXC] = 1'b1;
          if (st_r.scl_wait)
            st_nxt.scl_hold = 1'b1; // R04
        end
      end
    end

    // Clock line held low until software drops the wait
    if (!st_nxt.scl_wait)
      st_nxt.scl_hold = 1'b0;
    st_nxt.pins.scl_out = 1'b0;
    st_nxt.pins.scl_oe_n = !st_nxt.scl_hold;

    // Sticky events; a set in the clearing cycle survives
    st_nxt.irq_stat = st_nxt.irq_stat | ev;
    st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_en);
  end

  // Single state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= '0;
      st_r.ctrl <= CTRL_RST;
      st_r.baud <= BAUD_W'(BAUD_RST);
      st_r.txe <= 1'b1;
      st_r.rx_st <= RX_IDLE;
      st_r.scl_prev <= 1'b1;
      st_r.rxd_prev <= 1'b1;
      st_r.pins.txd <= 1'b1;
      st_r.pins.scl_out <= 1'b0;
      st_r.pins.scl_oe_n <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  assign awready = st_r.awready;
  assign wready = st_r.wready;
  assign bvalid = st_r.bvalid;
  assign bresp = st_r.bresp;
  assign arready = st_r.arready;
  assign rvalid = st_r.rvalid;
  assign rdata = st_r.rdata;
  assign rresp = st_r.rresp;
  assign pins = st_r.pins;
  assign irq = st_r.irq;
endmodule
`default_nettype wire

// >>> testbench/serial_mp_uart_checker.sv
// Purpose: Port checks of the multiprocessor serial unit.
// Assumes: The bench offers write address and write data in the same cycle.
// Notes: The start-init enable is shadowed from writes to the control register.
`default_nettype none
module serial_mp_uart_checker
  import serial_mp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [serial_mp_pkg::ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic rx_data_input,
  input wire logic scl_in,
  input wire serial_mp_pkg::pins_t pins
);
  timeunit 1ns;
  timeprecision 100ps;
  logic init_en_r;
  logic scl_q;
  logic rx_q;
  logic start_det;
  // Line history idles high so a reset never looks like a start
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      init_en_r <= 1'b0;
      scl_q <= 1'b1;
      rx_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_in;
      rx_q <= rx_data_input;
      if (awvalid && awready && wvalid && wready && awaddr == OFS_CTRL && wstrb[1])
        init_en_r <= wdata[11];
    end
  end
  assign start_det = init_en_r && scl_q && scl_in && rx_q && !rx_data_input;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence start_seen;
    start_det ##1 scl_in [*3];
  endsequence
  sequence write_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  AST_TXD_HELD: assert property (start_seen |-> $stable(pins.txd))
    else $error("data output moved before the first clock fall");
  AST_CLK_LOW_CAUSE: assert property ($fell(pins.scl_oe_n) |-> init_en_r)
    else $error("clock line pulled low outside start-triggered mode");
  AST_CLK_RELEASE: assert property ($rose(pins.scl_oe_n) |-> bvalid || $past(bvalid))
    else $error("clock line released without a register write");
  AST_READ_ANSWER: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered");
  AST_READ_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped before acceptance");
  AST_WRITE_ANSWER: assert property (write_taken |-> ##[1:2] bvalid)
    else $error("write not answered");
  AST_WRITE_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before acceptance");
  AST_NO_AR_WHILE_R: assert property (rvalid |-> !arready)
    else $error("read address accepted while a read is open");
  AST_NO_AW_WHILE_B: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while a response is open");
endmodule

bind serial_mp_uart serial_mp_uart_checker checker_i (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
  .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
  .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
  .rready(rready), .rdata(rdata), .rx_data_input(rx_data_input), .scl_in(scl_in), .pins(pins)
);
`default_nettype wire

// >>> testbench/line_station.sv
// Purpose: Far station on the shared serial line.
// Assumes: A tick every per clocks; a bit lasts 16 ticks.
// Notes: The line idles high like the pulled-up wire.
`default_nettype none
module line_station (
  input wire logic aclk,
  input wire logic txd,
  output logic line
);
  timeunit 1ns;
  timeprecision 100ps;
  initial line = 1'b1;
  // LSB first; a spike flips the line for two ticks from each bit middle to tease the filter
  task automatic send_frame(input logic [7:0] d, input logic mp, input int per, input logic spike);
    logic [10:0] f;
    f = {1'b1, mp, d, 1'b0};
    for (int b = 0; b < 11; b++)
      for (int c = 0; c < 16 * per; c++)
      begin
        @(posedge aclk);
        line <= f[b] ^ (spike && c >= 8 * per && c < 10 * per);
      end
  endtask
  // Mid-bit samples after the start edge: data, extra bit, stop
  task automatic hear_frame(output logic [9:0] v, input int per);
    int n;
    n = 0;
    while (txd !== 1'b0 && n < 4000)
    begin
      @(posedge aclk);
      n++;
    end
    repeat (8 * per) @(posedge aclk);
    for (int b = 0; b < 10; b++)
    begin
      repeat (16 * per) @(posedge aclk);
      v[b] = txd;
    end
  endtask
endmodule
`default_nettype wire

// >>> testbench/tb_serial_mp_uart.sv
// Purpose: Self-checking bench of the multiprocessor serial unit.
// Assumes: BAUD 0 or 1, so a bit lasts 16 or 32 clocks.
// Notes: Start-triggered transfers are clocked by the bench on scl_in.
`default_nettype none
module tb_serial_mp_uart
  import serial_mp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk;
  logic aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
  logic scl_in = 1'b1, sda = 1'b1, sync_sel = 1'b0;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0, rdata, rd_val;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, irq, st_line, rx_wire;
  logic [1:0] bresp, rresp, resp;
  logic [9:0] heard;
  logic [8:0] got;
  logic [8:0] tx_tab [2] = '{9'h15a, 9'h0a5};
  pins_t pins;
  int mismatches = 0, total_checks = 0, cycles = 0;

  serial_mp_uart DUT (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp), .rx_data_input(rx_wire), .scl_in(scl_in),
    .pins(pins), .irq(irq)
  );
  line_station station (.aclk(aclk), .txd(pins.txd), .line(st_line));
  // Bench owns the data line from the start-triggered transfer to the end of the run
  assign rx_wire = sync_sel ? sda : st_line;

  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Each channel is released at its own handshake; response ready stays high
  task automatic axi_write(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        r = bresp;
        break;
      end
    end
  endtask

  task automatic axi_read(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid && rready)
      begin
        d = rdata;
        r = rresp;
        break;
      end
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    axi_write(a, d, resp);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    axi_read(a, rd_val, resp);
    check(rd_val, exp);
  endtask

  // Cycle ceiling cuts a hang short; the run needs under 10000 cycles
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      mismatches++;
      complete_run();
    end
  end

  // Register map, multiprocessor frames, filter, then start-triggered transfer
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(OFS_BAUD, 32'h1);
    rd_chk(OFS_STAT, 32'h1);
    axi_write(6'h20, 32'h1, resp);
    check({30'h0, resp}, {30'h0, RESP_SLVERR});
    axi_read(6'h24, rd_val, resp);
    check({30'h0, resp}, {30'h0, RESP_SLVERR});
    check(rd_val, 32'h0);
    wr(OFS_BAUD, 32'h0);
    wr(OFS_IRQ_EN, 32'h1f);
    wr(OFS_CTRL, 32'h355);
    for (int i = 0; i < 2; i++)
    begin
      wr(OFS_TXBUF, {23'h0, tx_tab[i]});
      station.hear_frame(heard, 1);
      check({22'h0, heard}, {22'h0, 1'b1, tx_tab[i]});
    end
    wr(OFS_IRQ_CLR, 32'h1f);
    wr(OFS_CTRL, 32'h3d5);
    station.send_frame(8'h33, 1'b0, 1, 1'b0);
    repeat (20) @(posedge aclk);
    rd_chk(OFS_STAT, 32'h5);
    rd_chk(OFS_IRQ_STAT, 32'h0);
    station.send_frame(8'h42, 1'b1, 1, 1'b0);
    repeat (20) @(posedge aclk);
    check({31'h0, irq}, 32'h1);
    rd_chk(OFS_STAT, 32'h3);
    rd_chk(OFS_IRQ_STAT, 32'h0a);
    rd_chk(OFS_RXBUF, 32'h142);
    wr(OFS_IRQ_CLR, 32'h1f);
    @(posedge aclk);
    check({31'h0, irq}, 32'h0);
    wr(OFS_IRQ_EN, 32'h0);
    station.send_frame(8'h76, 1'b0, 1, 1'b0);
    repeat (20) @(posedge aclk);
    rd_chk(OFS_IRQ_STAT, 32'h2);
    check({31'h0, irq}, 32'h0);
    rd_chk(OFS_RXBUF, 32'h076);
    wr(OFS_BAUD, 32'h1);
    wr(OFS_CTRL, 32'h755);
    station.send_frame(8'h5a, 1'b0, 2, 1'b1);
    repeat (40) @(posedge aclk);
    rd_chk(OFS_RXBUF, 32'h05a);
    wr(OFS_CTRL, 32'h1a05);
    wr(OFS_TXBUF, 32'h96);
    rd_chk(OFS_STAT, 32'h0);
    sync_sel <= 1'b1;
    @(posedge aclk);
    sda <= 1'b0;
    repeat (4) @(posedge aclk);
    // Data changes only while the clock is low, MSB first
    for (int i = 0; i < 9; i++)
    begin
      scl_in <= 1'b0;
      @(posedge aclk);
      sda <= (i < 8) ? 1'(8'hc3 >> (7 - i)) : 1'b1;
      repeat (3) @(posedge aclk);
      got[8 - i] = pins.txd;
      scl_in <= 1'b1;
      repeat (4) @(posedge aclk);
    end
    scl_in <= 1'b0;
    repeat (4) @(posedge aclk);
    check({31'h0, pins.scl_oe_n}, 32'h0);
    check({31'h0, pins.scl_out}, 32'h0);
    sda <= 1'b1;
    check({23'h0, got}, 32'h12d);
    rd_chk(OFS_STAT, 32'ha);
    axi_read(OFS_RXBUF, rd_val, resp);
    check(rd_val & 32'hff, 32'hc3);
    wr(OFS_STAT, 32'h0);
    scl_in <= 1'b1;
    repeat (3) @(posedge aclk);
    check({31'h0, pins.scl_oe_n}, 32'h1);
    complete_run();
  end
endmodule
`default_nettype wire
